/* File: cmpdc_pkg.sv */
// Shared constants and state types for the comparator digital control.
// Assumes one 100 MHz core clock and an AHB-Lite register bus.
// Operation
// - Hysteresis only while its enable bit set.
// - Sync bit routes Timer1-latched output.
// - Latch on Timer1 clock falling edge.
// - Prescale input picks the prescaled or source Timer1 clock for the latch.
// - Comparator output drives Timer1 gate source.
// - Enabled edge detector sets interrupt flag.
// - Software clears flag; coincident edge wins.
// - Polarity toggle, or on toggle while input high, raises edge.
// - Three-bit field selects positive input.
// - Three-bit field selects negative input.
// - Comparator off disconnects all inputs.
// - Shared pin with op-amp feeds amplifier output to inverting input.
// - Mirror reads outputs at bits 1:0.
// - Gain field selects 4x, 2x, 1x, off.
// - Ready flag needs enable and ready.
package cmpdc_pkg;
    // Register byte offsets on the bus.
    localparam logic [7:0] OFS_CTL_FIRST_A = 8'h00;
    localparam logic [7:0] OFS_CTL_FIRST_B = 8'h04;
    localparam logic [7:0] OFS_CTL_SECOND_A = 8'h08;
    localparam logic [7:0] OFS_CTL_SECOND_B = 8'h0c;
    localparam logic [7:0] OFS_MIRROR = 8'h10;
    localparam logic [7:0] OFS_FIXED_REF = 8'h14;
    localparam logic [7:0] OFS_FLAG = 8'h18;
    // Field positions of the first control register.
    localparam int ON_BIT = 7;
    localparam int OUT_BIT = 6;
    localparam int POL_BIT = 4;
    localparam int SP_BIT = 2;
    localparam int HYS_BIT = 1;
    localparam int SYNC_BIT = 0;
    // Field positions of the second control register.
    localparam int INTP_BIT = 7;
    localparam int INTN_BIT = 6;
    localparam int PCH_LSB = 3;
    localparam int NCH_LSB = 0;
    // Field positions of the fixed reference control register.
    localparam int REN_BIT = 7;
    localparam int RDY_BIT = 6;
    localparam int GAIN_LSB = 2;
    // Writable masks and reset values.
    localparam logic [7:0] MASK_CTL_FIRST = 8'h9f;
    localparam logic [7:0] MASK_CTL_SECOND = 8'hff;
    localparam logic [7:0] MASK_FIXED_REF = 8'hbf;
    localparam logic [7:0] RST_REG = 8'h00;
    // Input select codes.
    localparam logic [2:0] PCH_PIN = 3'h0;
    localparam logic [2:0] PCH_DAC = 3'h1;
    localparam logic [2:0] PCH_FVR = 3'h2;
    localparam logic [2:0] PCH_GND = 3'h3;
    localparam logic [2:0] NCH_PIN = 3'h0;
    localparam logic [2:0] NCH_PIN_SHARED = 3'h1;
    localparam logic [2:0] NCH_FVR = 3'h2;
    localparam logic [2:0] NCH_GND = 3'h3;
    // Comparator buffer gain codes.
    localparam logic [1:0] GAIN_OFF = 2'h0;
    localparam logic [1:0] GAIN_1X = 2'h1;
    localparam logic [1:0] GAIN_2X = 2'h2;
    localparam logic [1:0] GAIN_4X = 2'h3;
    // Bus constants.
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic OKAY = 1'b0;

    // State of one edge detector.
    typedef struct packed {
        logic cur;
        logic prev;
        logic flag;
    } cmpdc_edge_state_t;

    // State of the main block.
    typedef struct packed {
        logic [1:0][7:0] ctl_first;
        logic [1:0][7:0] ctl_second;
        logic [7:0] fixed_ref;
        logic [1:0] raw_s1;
        logic [1:0] raw_s2;
        logic rdy_s1;
        logic rdy_s2;
        logic wr_pend;
        logic rd_pend;
        logic hi_zero;
        logic [7:0] addr;
        logic [31:0] rdata;
    } cmpdc_main_state_t;
endpackage

/* File: cmpdc_t1_latch.sv */
// Timer1-synchronised latch for the comparator outputs.
// Assumes Timer1 clocks arrive asynchronously and are sampled here.
`timescale 1ns/100ps
module cmpdc_t1_latch
    import cmpdc_pkg::*;
#(
    parameter int N = 2
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic timer_src_clk_in,
    input wire logic timer_pre_clk_in,
    input wire logic prescale_on_in,
    input wire logic [N-1:0] d_in,
    output logic [N-1:0] q_out
);
    // Synchroniser stages, edge history and latched value.
    typedef struct packed {
        logic t_s1;
        logic t_s2;
        logic t_prev;
        logic p_s1;
        logic p_s2;
        logic p_prev;
        logic [N-1:0] q;
    } cmpdc_latch_state_t;

    cmpdc_latch_state_t st, next_st;
    logic src_fall;
    logic pre_fall;
    logic fall;

    if (N < 1) begin : g_chk
        $error("cmpdc_t1_latch needs N of at least one");
    end

    ////////////////////////////////////////////////////////////////////
    // Falling edges of both Timer1 clocks; Timer1 counts on the rising
    // edge, so capturing on the falling one keeps the gate stable.
    always_comb begin
        src_fall = st.t_prev & ~st.t_s2;
        pre_fall = st.p_prev & ~st.p_s2;
        fall = prescale_on_in ? pre_fall : src_fall;
        next_st = st;
        next_st.t_s1 = timer_src_clk_in;
        next_st.t_s2 = st.t_s1;
        next_st.t_prev = st.t_s2;
        next_st.p_s1 = timer_pre_clk_in;
        next_st.p_s2 = st.p_s1;
        next_st.p_prev = st.p_s2;
        if (fall) begin
            next_st.q = d_in;
        end
    end

    // State register; everything clears on reset.
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q_out = st.q;

    ////////////////////////////////////////////////////////////////////
    // Checks.
    a_latch_hold: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in) !fall |=> $stable(st.q))
        else $error("latch changed without a falling edge");
    a_pre_capture: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in)
        (prescale_on_in && pre_fall) |=> st.q == $past(d_in))
        else $error("prescaled edge did not capture");
    c_latch_fall: cover property (@(posedge core_clk_in)
        disable iff (!rstn_in) fall);
endmodule

/* File: cmpdc_edge_det.sv */
// Rising and falling edge detector with a sticky interrupt flag.
// Assumes its level input comes from logic on the same clock.
`timescale 1ns/100ps
module cmpdc_edge_det
    import cmpdc_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic level_in,
    input wire logic rise_en_in,
    input wire logic fall_en_in,
    input wire logic clear_in,
    output logic level_out,
    output logic flag_out
);
    cmpdc_edge_state_t st, next_st;
    logic fire;

    ////////////////////////////////////////////////////////////////////
    // Compare the current level with the one a cycle earlier.
    always_comb begin
        fire = (rise_en_in & st.cur & ~st.prev)
            | (fall_en_in & ~st.cur & st.prev);
        next_st.cur = level_in;
        next_st.prev = st.cur;
        // A new edge beats a clearing write in the same cycle.
        next_st.flag = fire | (st.flag & ~clear_in);
    end

    // State register; history and flag clear on reset.
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level_out = st.cur;
    assign flag_out = st.flag;

    ////////////////////////////////////////////////////////////////////
    // Checks.
    a_rise_sets: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in)
        (rise_en_in && st.cur && !st.prev) |=> st.flag)
        else $error("rising edge did not set flag");
    a_clear_wins: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in)
        (clear_in && !fire) |=> !st.flag)
        else $error("flag not cleared");
    a_set_beats: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in) (clear_in && fire) |=> st.flag)
        else $error("edge lost on clear");
    c_set_clear: cover property (@(posedge core_clk_in)
        disable iff (!rstn_in) clear_in && fire);
endmodule

/* File: cmpdc_top.sv */
// Comparator digital control: registers, synchronisation, edges.
// Assumes a single AHB-Lite master and asynchronous analog inputs.
`timescale 1ns/100ps
module cmpdc_top
    import cmpdc_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out,
    input wire logic [1:0] cmp_raw_in,
    input wire logic timer_src_clk_in,
    input wire logic timer_pre_clk_in,
    input wire logic timer_prescale_on_in,
    input wire logic reference_ready_in,
    input wire logic [1:0] opamp_enable_in,
    output logic [1:0] comparator_on_out,
    output logic [1:0] hysteresis_enable_out,
    output logic [1:0] speed_power_select_out,
    output logic [1:0] inputs_connect_out,
    output logic [5:0] positive_input_select_out,
    output logic [5:0] negative_input_select_out,
    output logic [1:0] opamp_to_inverting_out,
    output logic [1:0] timer_gate_out,
    output logic [1:0] comparator_int_flag_out,
    output logic [1:0] comparator_buffer_gain_out,
    output logic comparator_buffer_on_out,
    output logic reference_enable_out,
    output logic reference_ready_flag_out
);
    // Main state and its next value.
    cmpdc_main_state_t st, next_st;
    // Polarised comparator levels before the optional synchroniser.
    logic [1:0] polar;
    // Timer1-latched copies of the polarised levels.
    logic [1:0] latched;
    // Level that feeds the edge detectors and the Timer1 gate.
    logic [1:0] routed;
    // Registered levels and flags from the edge detectors.
    logic [1:0] level;
    logic [1:0] flag;
    // Per-comparator flag clear pulses from a bus write.
    logic [1:0] clear;
    // Bus request taken in this cycle.
    logic take;
    // Data phase write that is to be applied now.
    logic wr_now;
    // Comparator on, polarity and sync bits.
    logic [1:0] on;
    logic [1:0] pol;
    logic [1:0] sync_en;

    ////////////////////////////////////////////////////////////////////
    // Returns the read value of a register at a byte offset.
    function automatic logic [7:0] reg_read(
        input cmpdc_main_state_t s,
        input logic [7:0] ofs,
        input logic [1:0] lv,
        input logic [1:0] fl
    );
        logic [7:0] v;
        v = 8'h00;
        unique case (ofs)
            OFS_CTL_FIRST_A: begin
                v = s.ctl_first[0] & MASK_CTL_FIRST;
                v[OUT_BIT] = lv[0];
            end
            OFS_CTL_FIRST_B: begin
                v = s.ctl_first[1] & MASK_CTL_FIRST;
                v[OUT_BIT] = lv[1];
            end
            OFS_CTL_SECOND_A: v = s.ctl_second[0];
            OFS_CTL_SECOND_B: v = s.ctl_second[1];
            // Bits 7 to 2 of the mirror stay zero.
            OFS_MIRROR: v = {6'h00, lv};
            OFS_FIXED_REF: begin
                v = s.fixed_ref & MASK_FIXED_REF;
                v[RDY_BIT] = s.fixed_ref[REN_BIT] & s.rdy_s2;
            end
            OFS_FLAG: v = {6'h00, fl};
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Comparator path: the output is forced low while off, then the
    // polarity inverts it, so toggling polarity makes an edge, and toggling on does so while the raw level is high.
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            on[i] = st.ctl_first[i][ON_BIT];
            pol[i] = st.ctl_first[i][POL_BIT];
            sync_en[i] = st.ctl_first[i][SYNC_BIT];
            polar[i] = (on[i] & st.raw_s2[i]) ^ pol[i];
            routed[i] = sync_en[i] ? latched[i] : polar[i];
        end
    end

    // Timer1 latch for both comparators.
    cmpdc_t1_latch #(
        .N(2)
    ) u_latch (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .timer_src_clk_in(timer_src_clk_in),
        .timer_pre_clk_in(timer_pre_clk_in),
        .prescale_on_in(timer_prescale_on_in),
        .d_in(polar),
        .q_out(latched)
    );

    // One edge detector per comparator.
    for (genvar g = 0; g < 2; g++) begin : g_edge
        cmpdc_edge_det u_edge (
            .core_clk_in(core_clk_in),
            .rstn_in(rstn_in),
            .level_in(routed[g]),
            .rise_en_in(st.ctl_second[g][INTP_BIT]),
            .fall_en_in(st.ctl_second[g][INTN_BIT]),
            .clear_in(clear[g]),
            .level_out(level[g]),
            .flag_out(flag[g])
        );
    end

    ////////////////////////////////////////////////////////////////////
    // Bus slave. Writes finish with no wait; reads take one wait state
    // so that the read data comes from a flop and sees prior writes.
    always_comb begin
        take = hsel_in & htrans_in[1] & hready_in & ~st.rd_pend;
        wr_now = st.wr_pend & st.hi_zero;
        for (int i = 0; i < 2; i++) begin
            clear[i] = wr_now & (st.addr == OFS_FLAG) & hwdata_in[i];
        end
    end

    // Next state: synchronisers, register writes and bus sequencing.
    always_comb begin
        next_st = st;
        // Analog and reference levels pass two flops first.
        next_st.raw_s1 = cmp_raw_in;
        next_st.raw_s2 = st.raw_s1;
        next_st.rdy_s1 = reference_ready_in;
        next_st.rdy_s2 = st.rdy_s1;
        next_st.wr_pend = 1'b0;
        next_st.rd_pend = 1'b0;
        // Apply the write in its data phase; unmapped writes drop.
        if (wr_now) begin
            unique case (st.addr)
                OFS_CTL_FIRST_A: next_st.ctl_first[0] =
                    hwdata_in[7:0] & MASK_CTL_FIRST;
                OFS_CTL_FIRST_B: next_st.ctl_first[1] =
                    hwdata_in[7:0] & MASK_CTL_FIRST;
                OFS_CTL_SECOND_A: next_st.ctl_second[0] =
                    hwdata_in[7:0] & MASK_CTL_SECOND;
                OFS_CTL_SECOND_B: next_st.ctl_second[1] =
                    hwdata_in[7:0] & MASK_CTL_SECOND;
                OFS_FIXED_REF: next_st.fixed_ref =
                    hwdata_in[7:0] & MASK_FIXED_REF;
                default: next_st.fixed_ref = st.fixed_ref;
            endcase
        end
        // Read data is captured in the wait cycle.
        if (st.rd_pend) begin
            next_st.rdata = 32'h0000_0000;
            if (st.hi_zero) begin
                next_st.rdata[7:0] = reg_read(st, st.addr, level, flag);
            end
        end
        // Address phase; only whole-word writes are applied.
        if (take) begin
            next_st.addr = haddr_in[7:0];
            next_st.hi_zero = (haddr_in[31:8] == 24'h00_0000);
            next_st.wr_pend = hwrite_in & (hsize_in == HSIZE_WORD);
            next_st.rd_pend = ~hwrite_in;
        end
    end

    // State register.
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs.
    assign hreadyout_out = ~st.rd_pend;
    assign hresp_out = OKAY;
    assign hrdata_out = st.rdata;
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            comparator_on_out[i] = on[i];
            hysteresis_enable_out[i] = st.ctl_first[i][HYS_BIT];
            speed_power_select_out[i] = st.ctl_first[i][SP_BIT];
            // All inputs float while the comparator is off.
            inputs_connect_out[i] = on[i];
            positive_input_select_out[3*i +: 3] =
                st.ctl_second[i][PCH_LSB +: 3];
            negative_input_select_out[3*i +: 3] =
                st.ctl_second[i][NCH_LSB +: 3];
            opamp_to_inverting_out[i] = on[i] & opamp_enable_in[i]
                & (st.ctl_second[i][NCH_LSB +: 3] == NCH_PIN_SHARED);
        end
    end
    assign timer_gate_out = level;
    assign comparator_int_flag_out = flag;
    assign comparator_buffer_gain_out = st.fixed_ref[GAIN_LSB +: 2];
    assign comparator_buffer_on_out =
        (st.fixed_ref[GAIN_LSB +: 2] != GAIN_OFF);
    assign reference_enable_out = st.fixed_ref[REN_BIT];
    assign reference_ready_flag_out =
        st.fixed_ref[REN_BIT] & st.rdy_s2;

    ////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rstn_in);

    a_hys_write: assert property (
        (wr_now && st.addr == OFS_CTL_FIRST_A)
        |=> hysteresis_enable_out[0] == $past(hwdata_in[HYS_BIT]))
        else $error("hysteresis bit not taken from write");
    a_sync_route: assert property (
        $past(sync_en[0]) |-> level[0] == $past(latched[0]))
        else $error("sync path not routed");
    a_pol_edge: assert property (
        (!on[0] && $past(!on[0]) && !sync_en[0] && $past(!sync_en[0])
        && $changed(pol[0])) |=> level[0] != $past(level[0]))
        else $error("polarity toggle gave no edge");
    a_off_float: assert property (
        !on[1] |-> !inputs_connect_out[1] && !opamp_to_inverting_out[1])
        else $error("inputs connected while off");
    a_mirror_read: assert property (
        (st.rd_pend && st.hi_zero && st.addr == OFS_MIRROR)
        |=> hrdata_out[31:2] == 30'h0 && hrdata_out[1:0] == $past(level))
        else $error("mirror read wrong");
    a_gain_off: assert property (
        (st.fixed_ref[GAIN_LSB +: 2] == GAIN_OFF) |-> !comparator_buffer_on_out)
        else $error("buffer on with gain off");
    a_ready_enable: assert property (
        !reference_enable_out |-> !reference_ready_flag_out)
        else $error("ready flag without enable");
    a_read_wait: assert property (
        (take && !hwrite_in) |=> !hreadyout_out ##1 hreadyout_out)
        else $error("read wait state wrong");

    c_flag_set: cover property ($rose(flag[0]));
    c_sync_gate: cover property (sync_en[1] && $changed(level[1]));
    c_flag_clear: cover property ($fell(flag[1]));
endmodule

/* File: cmpdc_t1_model.sv */
// Stand-in for Timer1 gate counting and the interrupt controller.
// Assumes the timer clock comes from the bench and idles high.
`timescale 1ns/100ps
module cmpdc_t1_model (
    input wire logic timer_clk_in,
    input wire logic [1:0] gate_in,
    input wire logic [1:0] flag_in,
    input wire logic [1:0] int_en_in,
    output logic [7:0] count_out,
    output logic irq_out
);
    ////////////////////////////////////////////////////////////////////////
    // The timer counts on the rising edge only, so a latch that moves on
    // the falling edge can never race it.
    initial count_out = 8'h00;
    always @(posedge timer_clk_in) begin
        if (gate_in[0]) begin
            count_out <= count_out + 8'h01;
        end
    end
    // Peripheral and global enables are folded into one mask here.
    assign irq_out = |(flag_in & int_en_in);
endmodule

/* File: tb_cmpdc_top.sv */
// Self-checking bench for the comparator digital control.
// Assumes cmpdc_pkg and the timer model are compiled first.
`timescale 1ns/100ps
module tb_cmpdc_top
    import cmpdc_pkg::*;
;
    logic clk, rstn, hsel, hwrite, hrdy, hresp, tsrc, tpre, pon, rdy;
    logic [1:0] htrans, raw, oen, ie, con, hys, sp, icn, o2i, gate, flg;
    logic [1:0] gain;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd_v;
    logic [5:0] ps, ns;
    logic bon, ren, rfl, irq;
    logic [7:0] cnt, c0;
    int n_mismatch = 0;
    int checks = 0;

    ////////////////////////////////////////////////////////////////////////
    // The slave's hreadyout is the bus hready.
    cmpdc_top u_dut (.core_clk_in(clk), .rstn_in(rstn), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hrdy),
        .hreadyout_out(hrdy), .hresp_out(hresp), .hrdata_out(hrdata),
        .cmp_raw_in(raw), .timer_src_clk_in(tsrc), .timer_pre_clk_in(tpre),
        .timer_prescale_on_in(pon), .reference_ready_in(rdy),
        .opamp_enable_in(oen), .comparator_on_out(con),
        .hysteresis_enable_out(hys), .speed_power_select_out(sp),
        .inputs_connect_out(icn), .positive_input_select_out(ps),
        .negative_input_select_out(ns), .opamp_to_inverting_out(o2i),
        .timer_gate_out(gate), .comparator_int_flag_out(flg),
        .comparator_buffer_gain_out(gain), .comparator_buffer_on_out(bon),
        .reference_enable_out(ren), .reference_ready_flag_out(rfl));
    cmpdc_t1_model u_t1 (.timer_clk_in(tsrc), .gate_in(gate),
        .flag_in(flg), .int_en_in(ie), .count_out(cnt), .irq_out(irq));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Counts every comparison and reports a mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Hready is looked at before the edge so the flop update cannot race
    // the bench; read data are taken on that same falling edge.
    task automatic wait_rdy();
        logic ok;
        ok = 1'b0;
        while (!ok) begin
            @(negedge clk);
            ok = (hrdy === 1'b1);
            rd_v = hrdata;
            @(posedge clk);
        end
    endtask

    // One single-word transfer: address phase, then data phase.
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        hsel <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rd_v, e);
        // The slave never answers with an error.
        chk({31'h0, hresp}, 32'h0);
    endtask

    // Lands on a falling edge, where every output has settled.
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic end_of_test();
        if (n_mismatch == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Cuts a hang short; the tests need well under this span.
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence. Timer clocks idle high so nothing latches by itself.
    initial begin
        rstn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h0;
        raw = 2'h0;
        tsrc = 1'b1;
        tpre = 1'b1;
        pon = 1'b0;
        rdy = 1'b0;
        oen = 2'h0;
        ie = 2'h0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        for (int a = 0; a <= 24; a += 4) begin
            rd(a, 32'h0);
        end
        rd(32'h100, 32'h0);
        // The sync bit is set but no timer edge comes, so output stays 0.
        wr(32'h0, 32'hff);
        rd(32'h0, 32'h9f);
        wr(32'h4, 32'h06);
        rd(32'h4, 32'h06);
        wt(1);
        chk({24'h0, con, hys, sp, icn}, 32'h7d);
        wr(32'h0, 32'h0);
        wr(32'h4, 32'h0);
        // Input selects, and the amplifier takes over only while on.
        @(posedge clk);
        oen <= 2'h3;
        wr(32'h8, 32'hd1);
        wr(32'hc, 32'h1a);
        wt(1);
        chk({20'h0, ps, ns}, 32'h691);
        chk({30'h0, o2i}, 32'h0);
        wr(32'h0, 32'h80);
        wt(2);
        chk({30'h0, o2i}, 32'h1);
        // Both edges enabled on comparator one; the software side sets
        // up the enables first.
        @(posedge clk);
        raw <= 2'h1;
        ie <= 2'h1;
        wt(6);
        chk({27'h0, gate, flg, irq}, 32'hb);
        rd(32'h10, 32'h1);
        rd(32'h0, 32'hc0);
        rd(32'h18, 32'h1);
        wr(32'h18, 32'h1);
        wt(1);
        chk({30'h0, flg}, 32'h0);
        @(posedge clk);
        raw <= 2'h0;
        wt(6);
        chk({30'h0, flg}, 32'h1);
        // Rising edge only from here on.
        wr(32'h8, 32'h91);
        wr(32'h18, 32'h1);
        @(posedge clk);
        raw <= 2'h1;
        wt(6);
        chk({30'h0, flg}, 32'h1);
        wr(32'h18, 32'h1);
        @(posedge clk);
        raw <= 2'h0;
        wt(6);
        chk({30'h0, flg}, 32'h0);
        // Edges made by polarity and on toggles while switched off.
        wr(32'h0, 32'h0);
        @(posedge clk);
        raw <= 2'h1;
        wr(32'h18, 32'h1);
        wr(32'h0, 32'h10);
        wt(3);
        chk({30'h0, flg}, 32'h1);
        wr(32'h18, 32'h1);
        wr(32'h0, 32'h0);
        wr(32'h0, 32'h80);
        wt(3);
        chk({30'h0, flg}, 32'h1);
        // Clear lands before, on and after the edge that sets the flag.
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            raw <= 2'h0;
            wt(6);
            wr(32'h18, 32'h1);
            @(posedge clk);
            raw <= 2'h1;
            repeat (k) @(posedge clk);
            wr(32'h18, 32'h1);
            wt(6);
            chk({30'h0, flg}, (k < 2) ? 32'h1 : 32'h0);
        end
        // Synchronised path: only a falling timer edge moves the gate.
        wr(32'h0, 32'h81);
        @(posedge clk);
        raw <= 2'h0;
        tsrc <= 1'b0;
        wt(8);
        @(posedge clk);
        tsrc <= 1'b1;
        raw <= 2'h1;
        wt(10);
        chk({30'h0, gate}, 32'h0);
        @(posedge clk);
        tsrc <= 1'b0;
        wt(8);
        chk({30'h0, gate}, 32'h1);
        c0 = cnt;
        @(posedge clk);
        tsrc <= 1'b1;
        wt(4);
        chk({24'h0, cnt}, {24'h0, c0 + 8'h01});
        @(posedge clk);
        pon <= 1'b1;
        raw <= 2'h0;
        tsrc <= 1'b0;
        wt(8);
        chk({30'h0, gate}, 32'h1);
        @(posedge clk);
        tpre <= 1'b0;
        wt(8);
        chk({30'h0, gate}, 32'h0);
        @(posedge clk);
        tsrc <= 1'b1;
        tpre <= 1'b1;
        pon <= 1'b0;
        // Fixed reference: ready needs both enable and the analog flag.
        @(posedge clk);
        rdy <= 1'b1;
        wr(32'h14, 32'hff);
        rd(32'h14, 32'hff);
        for (int g = 0; g < 4; g++) begin
            wr(32'h14, 32'h80 | (g << 2));
            wt(1);
            chk({27'h0, gain, bon, ren, rfl},
                {27'h0, 2'(g), (g != 0), 2'h3});
        end
        wr(32'h14, 32'h0);
        rd(32'h14, 32'h0);
        @(posedge clk);
        rdy <= 1'b0;
        wr(32'h14, 32'h80);
        wt(3);
        rd(32'h14, 32'h80);
        // A byte-sized write is dropped, so the reference keeps its value.
        hsize <= 3'h0;
        wr(32'h14, 32'h0);
        hsize <= HSIZE_WORD;
        rd(32'h14, 32'h80);
        // Mirror ignores writes; an unmapped write changes nothing.
        wr(32'h10, 32'hff);
        rd(32'h10, 32'h0);
        wr(32'h100, 32'hff);
        rd(32'h100, 32'h0);
        // Reset in mid-run with the flag set.
        @(posedge clk);
        rstn <= 1'b0;
        wt(2);
        chk({26'h0, gate, flg, con}, 32'h0);
        @(posedge clk);
        rstn <= 1'b1;
        rd(32'h0, 32'h0);
        end_of_test();
    end
endmodule
